// >>> rtl/vpctl_dev.sv
/*
  write-only two-wire slave holding the preamp control registers.
  assumes the link wires are asynchronous and are sampled twice.
*/
// Contract
// - answer only address byte DC hex
// - writes only, no register read-back
// - host sends address, selector, data
// - every byte travels msb first
// - host ends each write with stop
// - further selector/data pairs without restart
// - detect gate bit enables active video flag
// - detect is OR of three comparators
// - plain dc: bit2 one, bit3 zero
// - ac or cut-off: bits 2,3,4 set
// - cathode feedback: bits 2,4 cleared
// - four-bit shared dc level in ac
// - three independent eight-bit cut-off registers
// - reset loads every register defined value
// - serial logic alive during stand-by
// - contrast and gains reset to 180
// - coupling bit 7 enables sync clipping
`timescale 1ns/1ps
`default_nettype none
module vpctl_dev (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // link
  vpctl_if.dev link,
  // analog side
  input wire logic [2:0] videoAbove,
  input wire logic standby,
  output logic activeVideoFlag,
  output logic [3:0] infraBlackOutputLevel,
  output logic [7:0] couplingMode,
  output logic [7:0] cutoff1,
  output logic [7:0] cutoff2,
  output logic [7:0] cutoff3,
  output logic [7:0] detectControl,
  output logic [7:0] contrastSetting,
  output logic [7:0] channelGainSetting1,
  output logic [7:0] channelGainSetting2,
  output logic [7:0] channelGainSetting3,
  output logic syncClipEnable,
  output logic acCouplingMode,
  output logic dcPlainMode,
  output logic dcFeedbackMode
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_RX = 4'b0010,
    S_ACK = 4'b0100,
    S_SKIP = 4'b1000
  } vpctl_st_t;
  logic [1:0] sclSync_r;
  logic [1:0] sdaSync_r;
  logic sclDly_r;
  logic sdaDly_r;
  vpctl_st_t state_r;
  logic [7:0] shift_r;
  logic [3:0] bitCnt_r;
  logic [1:0] phase_r;
  logic [7:0] selector_r;
  logic ackDrive_r;
  logic commitPend_r;
  logic [7:0] pendData_r;
  wire logic sclIn = sclSync_r[1];
  wire logic sdaIn = sdaSync_r[1];
  wire logic sclRise = sclIn && !sclDly_r;
  wire logic sclFall = !sclIn && sclDly_r;
  wire logic startCond = sclIn && sclDly_r && sdaDly_r && !sdaIn;
  wire logic stopCond = sclIn && sclDly_r && !sdaDly_r && sdaIn;
  logic [7:0] rxByte;
  always_comb
  begin
    rxByte = {shift_r[6:0], sdaIn};
  end
  // synchroniser stays on during stand-by, only reset presets it high
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sclSync_r <= 2'h3;
      sdaSync_r <= 2'h3;
      sclDly_r <= 1'b1;
      sdaDly_r <= 1'b1;
    end
    else
    begin
      sclSync_r <= {sclSync_r[0], link.scl};
      sdaSync_r <= {sdaSync_r[0], link.sda};
      sclDly_r <= sclSync_r[1];
      sdaDly_r <= sdaSync_r[1];
    end
  end
  // phase 0 = address, 1 = selector, 2 = data
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r <= S_IDLE;
      shift_r <= 8'h00;
      bitCnt_r <= 4'h0;
      phase_r <= 2'h0;
      selector_r <= 8'h00;
      ackDrive_r <= 1'b0;
      commitPend_r <= 1'b0;
      pendData_r <= 8'h00;
    end
    else if (startCond)
    begin
      state_r <= S_RX;
      bitCnt_r <= 4'h0;
      phase_r <= 2'h0;
      ackDrive_r <= 1'b0;
      commitPend_r <= 1'b0;
    end
    else if (stopCond)
    begin
      state_r <= S_IDLE;
      ackDrive_r <= 1'b0;
      commitPend_r <= 1'b0;
    end
    else
    begin
      commitPend_r <= 1'b0;
      case (state_r)
        S_IDLE:
        begin
          ackDrive_r <= 1'b0;
        end
        S_RX:
        begin
          if (sclRise)
          begin
            shift_r <= rxByte;
            bitCnt_r <= bitCnt_r + 4'h1;
          end
          else if (sclFall && bitCnt_r == 4'h8)
          begin
            bitCnt_r <= 4'h0;
            if (phase_r == 2'h0 && shift_r != vpctl_pkg::SLAVE_ADDR_BYTE)
              state_r <= S_SKIP;
            else
            begin
              state_r <= S_ACK;
              ackDrive_r <= 1'b1;
            end
          end
        end
        S_ACK:
        begin
          if (sclFall)
          begin
            ackDrive_r <= 1'b0;
            state_r <= S_RX;
            case (phase_r)
              2'h0: phase_r <= 2'h1;
              2'h1:
              begin
                selector_r <= shift_r;
                phase_r <= 2'h2;
              end
              default:
              begin
                pendData_r <= shift_r;
                commitPend_r <= 1'b1;
                phase_r <= 2'h1;
              end
            endcase
          end
        end
        S_SKIP:
        begin
          ackDrive_r <= 1'b0;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
  assign link.sdaDevOut = 1'b0;
  assign link.sdaDevOe = ackDrive_r;
  // register store: values defined from reset, written only by commit
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      infraBlackOutputLevel <= 4'h0;
      couplingMode <= vpctl_pkg::ZERO_RESET;
      cutoff1 <= vpctl_pkg::ZERO_RESET;
      cutoff2 <= vpctl_pkg::ZERO_RESET;
      cutoff3 <= vpctl_pkg::ZERO_RESET;
      detectControl <= vpctl_pkg::ZERO_RESET;
      contrastSetting <= vpctl_pkg::GAIN_RESET;
      channelGainSetting1 <= vpctl_pkg::GAIN_RESET;
      channelGainSetting2 <= vpctl_pkg::GAIN_RESET;
      channelGainSetting3 <= vpctl_pkg::GAIN_RESET;
    end
    else if (commitPend_r)
    begin
      case (selector_r)
        vpctl_pkg::REG_DC_LEVEL:
          infraBlackOutputLevel <= pendData_r[vpctl_pkg::DC_LEVEL_W-1:0];
        vpctl_pkg::REG_COUPLING: couplingMode <= pendData_r;
        vpctl_pkg::REG_CUTOFF1: cutoff1 <= pendData_r;
        vpctl_pkg::REG_CUTOFF2: cutoff2 <= pendData_r;
        vpctl_pkg::REG_CUTOFF3: cutoff3 <= pendData_r;
        vpctl_pkg::REG_DETECT: detectControl <= pendData_r;
        vpctl_pkg::REG_CONTRAST: contrastSetting <= pendData_r;
        vpctl_pkg::REG_GAIN1: channelGainSetting1 <= pendData_r;
        vpctl_pkg::REG_GAIN2: channelGainSetting2 <= pendData_r;
        vpctl_pkg::REG_GAIN3: channelGainSetting3 <= pendData_r;
        default: ;
      endcase
    end
  end
  // decoded modes; comparators and standby are async to clk so both are synchronised
  logic [2:0] videoSync0_r;
  logic [2:0] videoSync1_r;
  logic [1:0] standbySync_r;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      videoSync0_r <= 3'h0;
      videoSync1_r <= 3'h0;
      standbySync_r <= 2'h0;
      activeVideoFlag <= 1'b0;
      syncClipEnable <= 1'b0;
      acCouplingMode <= 1'b0;
      dcPlainMode <= 1'b0;
      dcFeedbackMode <= 1'b1; // cleared coupling register decodes as feedback mode
    end
    else
    begin
      videoSync0_r <= videoAbove;
      videoSync1_r <= videoSync0_r;
      standbySync_r <= {standbySync_r[0], standby};
      activeVideoFlag <= detectControl[vpctl_pkg::DETECT_GATE_BIT] && !standbySync_r[1]
        && (|videoSync1_r);
      syncClipEnable <= couplingMode[vpctl_pkg::SYNC_CLIP_BIT];
      acCouplingMode <= couplingMode[vpctl_pkg::CPL_BIT_A] && couplingMode[vpctl_pkg::CPL_BIT_B]
        && couplingMode[vpctl_pkg::CPL_BIT_C];
      dcPlainMode <= couplingMode[vpctl_pkg::CPL_BIT_A]
        && !couplingMode[vpctl_pkg::CPL_BIT_B];
      dcFeedbackMode <= !couplingMode[vpctl_pkg::CPL_BIT_A]
        && !couplingMode[vpctl_pkg::CPL_BIT_C];
    end
  end
endmodule
`default_nettype wire

// >>> rtl/vpctl_host.sv
/*
  two-wire master that writes one selector/data pair per command.
  assumes the user port below; link clock is made here by a divider.
*/
`timescale 1ns/1ps
`default_nettype none
module vpctl_host #(
  parameter int HALF_CYC = vpctl_pkg::SCL_HALF_CYC
) (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // user port
  input wire logic [3:0] hAddr,
  input wire logic [15:0] hWdata,
  input wire logic hWr,
  input wire logic hRd,
  output logic [15:0] hRdata,
  // link
  vpctl_if.host link
);
  typedef enum logic [5:0] {
    H_IDLE = 6'b000001,
    H_START = 6'b000010,
    H_BIT = 6'b000100,
    H_ACK = 6'b001000,
    H_STOP = 6'b010000,
    H_END = 6'b100000
  } vpctl_hst_t;
  vpctl_hst_t state_r;
  logic [15:0] cnt_r;
  logic [1:0] quarter_r;
  logic [23:0] frame_r;
  logic [4:0] bitIdx_r;
  logic sclLow_r;
  logic sdaLow_r;
  logic nackSeen_r;
  logic [1:0] sdaSync_r;
  wire logic tick = (cnt_r == 16'(HALF_CYC - 1));
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      sdaSync_r <= 2'h3;
    else
      sdaSync_r <= {sdaSync_r[0], link.sda};
  end
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cnt_r <= 16'h0000;
    else if (state_r == H_IDLE || tick)
      cnt_r <= 16'h0000;
    else
      cnt_r <= cnt_r + 16'h0001;
  end
  // each bit is three half periods: low half (quarter 0), then a low half and a high half (quarter 1)
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r <= H_IDLE;
      frame_r <= 24'h000000;
      bitIdx_r <= 5'h00;
      quarter_r <= 2'h0;
      sclLow_r <= 1'b0;
      sdaLow_r <= 1'b0;
      nackSeen_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        H_IDLE:
        begin
          if (hWr && hAddr == vpctl_pkg::HADDR_CMD)
          begin
            frame_r <= {vpctl_pkg::SLAVE_ADDR_BYTE, hWdata};
            nackSeen_r <= 1'b0;
            sdaLow_r <= 1'b1;
            state_r <= H_START;
          end
        end
        H_START:
          if (tick)
          begin
            sclLow_r <= 1'b1;
            bitIdx_r <= 5'h00;
            quarter_r <= 2'h0;
            state_r <= H_BIT;
          end
        H_BIT:
          if (tick)
          begin
            if (quarter_r == 2'h0)
            begin
              sdaLow_r <= !frame_r[23];
              sclLow_r <= 1'b1;
              quarter_r <= 2'h1;
            end
            else if (sclLow_r)
              sclLow_r <= 1'b0;
            else
            begin
              sclLow_r <= 1'b1;
              frame_r <= {frame_r[22:0], 1'b0};
              bitIdx_r <= bitIdx_r + 5'h01;
              quarter_r <= 2'h0;
              if (bitIdx_r[2:0] == 3'h7)
              begin
                sdaLow_r <= 1'b0;
                state_r <= H_ACK;
              end
            end
          end
        H_ACK:
          if (tick)
          begin
            if (sclLow_r)
              sclLow_r <= 1'b0;
            else
            begin
              nackSeen_r <= nackSeen_r | sdaSync_r[1];
              sclLow_r <= 1'b1;
              if (bitIdx_r == 5'h18 || sdaSync_r[1])
              begin
                sdaLow_r <= 1'b1;
                state_r <= H_STOP;
              end
              else
                state_r <= H_BIT;
            end
          end
        H_STOP:
          if (tick)
          begin
            if (sclLow_r)
              sclLow_r <= 1'b0;
            else
            begin
              sdaLow_r <= 1'b0;
              state_r <= H_END;
            end
          end
        H_END:
          if (tick)
            state_r <= H_IDLE;
        default: state_r <= H_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      hRdata <= 16'h0000;
    else if (hRd && hAddr == vpctl_pkg::HADDR_STAT)
      hRdata <= {14'h0000, nackSeen_r, state_r != H_IDLE};
    else
      hRdata <= 16'h0000;
  end
  assign link.sclOut = 1'b0;
  assign link.sclOe = sclLow_r;
  assign link.sdaHostOut = 1'b0;
  assign link.sdaHostOe = sdaLow_r;
endmodule
`default_nettype wire

// >>> rtl/vpctl_if.sv
/*
  two-wire link between the preamp control slave and its bus master.
  assumes both wires pulled up; a driver only pulls low.
*/
`timescale 1ns/1ps
`default_nettype none
interface vpctl_if;
  logic sclOut;
  logic sclOe;
  logic sdaHostOut;
  logic sdaHostOe;
  logic sdaDevOut;
  logic sdaDevOe;
  wire logic scl;
  wire logic sda;
  assign scl = !(sclOe && !sclOut);
  assign sda = !((sdaHostOe && !sdaHostOut) || (sdaDevOe && !sdaDevOut));
  modport host (output sclOut, sclOe, sdaHostOut, sdaHostOe, input scl, sda);
  modport dev (output sdaDevOut, sdaDevOe, input scl, sda);
endinterface
`default_nettype wire

// >>> rtl/vpctl_pkg.sv
/*
  constants shared by the preamp control slave and its bus master.
  assumes a 25 MHz system clock on both ends.
*/
package vpctl_pkg;
  localparam logic [7:0] SLAVE_ADDR_BYTE = 8'hDC;
  localparam logic [7:0] REG_DC_LEVEL = 8'h06;
  localparam logic [7:0] REG_COUPLING = 8'h09;
  localparam logic [7:0] REG_CUTOFF1 = 8'h0A;
  localparam logic [7:0] REG_CUTOFF2 = 8'h0B;
  localparam logic [7:0] REG_CUTOFF3 = 8'h0C;
  localparam logic [7:0] REG_DETECT = 8'h0D;
  localparam logic [7:0] REG_CONTRAST = 8'h01;
  localparam logic [7:0] REG_GAIN1 = 8'h03;
  localparam logic [7:0] REG_GAIN2 = 8'h04;
  localparam logic [7:0] REG_GAIN3 = 8'h05;
  localparam logic [7:0] GAIN_RESET = 8'hB4;
  localparam logic [7:0] ZERO_RESET = 8'h00;
  localparam int DC_LEVEL_W = 4;
  localparam int DETECT_GATE_BIT = 7;
  localparam int SYNC_CLIP_BIT = 7;
  localparam int CPL_BIT_A = 2;
  localparam int CPL_BIT_B = 3;
  localparam int CPL_BIT_C = 4;
  localparam int CLK_NS = 40;
  localparam int SCL_HALF_NS = 5000;
  localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] HADDR_CMD = 4'h0;
  localparam logic [3:0] HADDR_STAT = 4'h1;
endpackage

// >>> sim/tb.sv
/*
  testbench: master and slave joined by the link, model of the registers.
  assumes the host command and status ports of the master.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checksDone++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] hAddr = 4'h0;
  logic [15:0] hWdata = 16'h0000;
  logic hWr = 1'b0;
  logic hRd = 1'b0;
  logic [15:0] hRdata;
  logic [2:0] videoAbove = 3'h0;
  logic standby = 1'b0;
  logic [7:0] cpl, co1, co2, co3, det, con, g1, g2, g3;
  logic [3:0] dcl;
  logic av, clip, acm, dpm, dfm;
  int fails = 0;
  int checksDone = 0;
  logic [31:0] seed = 32'hE8E4F270;
  logic [7:0] expR [16];
  logic [7:0] sels [12] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
    8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0F};
  logic [7:0] cms [4] = '{8'h04, 8'h1C, 8'h00, 8'h80};
  vpctl_if link();
  vpctl_host #(.HALF_CYC(4)) vpctl_host_inst (.clk(clk), .sys_rst(sys_rst), .hAddr(hAddr),
    .hWdata(hWdata), .hWr(hWr), .hRd(hRd), .hRdata(hRdata), .link(link));
  vpctl_dev vpctl_dev_inst (.clk(clk), .sys_rst(sys_rst), .link(link),
    .videoAbove(videoAbove), .standby(standby), .activeVideoFlag(av),
    .infraBlackOutputLevel(dcl), .couplingMode(cpl), .cutoff1(co1), .cutoff2(co2),
    .cutoff3(co3), .detectControl(det), .contrastSetting(con), .channelGainSetting1(g1),
    .channelGainSetting2(g2), .channelGainSetting3(g3), .syncClipEnable(clip),
    .acCouplingMode(acm), .dcPlainMode(dpm), .dcFeedbackMode(dfm));
  vpctl_monitor #(.HALF_CYC(4)) vpctl_monitor_inst (.clk(clk), .sys_rst(sys_rst),
    .sclOut(link.sclOut), .sclOe(link.sclOe), .sdaHostOut(link.sdaHostOut),
    .sdaHostOe(link.sdaHostOe), .sdaDevOut(link.sdaDevOut), .sdaDevOe(link.sdaDevOe),
    .scl(link.scl), .sda(link.sda));
  always #20 clk = !clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic giveVerdict();
    $display("checks %0d fails %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic resetModel();
    foreach (expR[i]) expR[i] = 8'h00;
    expR[1] = 8'hB4;
    expR[3] = 8'hB4;
    expR[4] = 8'hB4;
    expR[5] = 8'hB4;
  endtask
  task automatic rdStat(output logic [15:0] v);
    @(posedge clk);
    hAddr <= 4'h1;
    hRd <= 1'b1;
    @(posedge clk);
    hRd <= 1'b0;
    #1 v = hRdata;
  endtask
  task automatic wr(input logic [7:0] s, input logic [7:0] d);
    logic [15:0] st;
    int k;
    @(posedge clk);
    hAddr <= 4'h0;
    hWdata <= {s, d};
    hWr <= 1'b1;
    @(posedge clk);
    hWr <= 1'b0;
    if (s inside {8'h01, 8'h03, 8'h04, 8'h05, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D})
      expR[s[3:0]] = d;
    if (s == 8'h06)
      expR[6] = {4'h0, d[3:0]};
    st = 16'h0001;
    k = 0;
    while (st[0] !== 1'b0 && k < 1000)
    begin
      rdStat(st);
      k++;
    end
    `CHK("busy", 1'b0, st[0])
    `CHK("nack", 1'b0, st[1])
    repeat (6) @(posedge clk);
  endtask
  task automatic chkAll();
    logic [7:0] m;
    m = expR[9];
    `CHK("contrast", expR[1], con)
    `CHK("gain1", expR[3], g1)
    `CHK("gain2", expR[4], g2)
    `CHK("gain3", expR[5], g3)
    `CHK("dcLevel", expR[6][3:0], dcl)
    `CHK("coupling", m, cpl)
    `CHK("cutoff1", expR[10], co1)
    `CHK("cutoff2", expR[11], co2)
    `CHK("cutoff3", expR[12], co3)
    `CHK("detect", expR[13], det)
    `CHK("syncClip", m[7], clip)
    `CHK("acMode", m[2] & m[3] & m[4], acm)
    `CHK("dcPlain", m[2] & !m[3], dpm)
    `CHK("dcFeedback", !m[2] & !m[4], dfm)
  endtask
  initial
  begin
    repeat (60000) @(posedge clk);
    fails++;
    giveVerdict();
  end
  initial
  begin
    resetModel();
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    // decoded modes settle one edge after release; look once they stand
    repeat (2) @(posedge clk);
    chkAll();
    $display("test reset values done");
    // standby toggles so writes land with the analog side off as well
    foreach (sels[i])
    begin
      seed = lfsr(seed);
      standby <= seed[8];
      wr(sels[i], seed[7:0]);
      chkAll();
    end
    standby <= 1'b0;
    $display("test register writes done");
    foreach (cms[j])
    begin
      wr(8'h09, cms[j]);
      chkAll();
    end
    $display("test coupling modes done");
    for (int g = 0; g < 2; g++)
    begin
      seed = lfsr(seed);
      wr(8'h0D, {g[0], seed[6:0]});
      for (int v = 0; v < 8; v++)
      begin
        videoAbove <= v[2:0];
        repeat (6) @(posedge clk);
        `CHK("avFlag", g == 1 && v != 0, av)
      end
    end
    standby <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK("avStandby", 1'b0, av)
    standby <= 1'b0;
    $display("test video detect done");
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    resetModel();
    repeat (2) @(posedge clk);
    chkAll();
    $display("test second reset done");
    giveVerdict();
  end
endmodule
`default_nettype wire

// >>> sim/vpctl_monitor.sv
/*
  checker for the two-wire link between the preamp slave and its master.
  assumes it is instantiated beside the link with the master's half-bit count.
*/
`timescale 1ns/1ps
`default_nettype none
module vpctl_monitor #(
  parameter int HALF_CYC = 4
) (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // drivers
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sdaHostOut,
  input wire logic sdaHostOe,
  input wire logic sdaDevOut,
  input wire logic sdaDevOe,
  // wires
  input wire logic scl,
  input wire logic sda
);
  // ack pull spans one scl low and one scl high plus sync slack on both edges
  localparam int OE_MAX = 2 * HALF_CYC + 8;
  logic sclQ;
  logic sdaQ;
  logic [3:0] bitCnt;
  logic [1:0] byteCnt;
  logic [7:0] shiftR;
  logic [7:0] oeCnt;
  wire logic sclRise = scl && !sclQ;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sclQ <= 1'b1;
      sdaQ <= 1'b1;
      bitCnt <= 4'h0;
      byteCnt <= 2'h0;
      shiftR <= 8'h00;
    end
    else
    begin
      sclQ <= scl;
      sdaQ <= sda;
      if (scl && sclQ && sdaQ && !sda)
      begin
        bitCnt <= 4'h0;
        byteCnt <= 2'h0;
      end
      else if (sclRise)
      begin
        shiftR <= {shiftR[6:0], sda};
        bitCnt <= (bitCnt == 4'h8) ? 4'h0 : bitCnt + 4'h1;
        if (bitCnt == 4'h8 && byteCnt != 2'h3)
          byteCnt <= byteCnt + 2'h1;
      end
    end
  end
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      oeCnt <= 8'h00;
    else
      oeCnt <= sdaDevOe ? oeCnt + 8'h01 : 8'h00;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_start;
    scl && sclQ && sdaQ && !sda;
  endsequence
  sequence s_ninth;
    sclRise && bitCnt == 4'h8;
  endsequence
  a_start_shape: assert property (s_start |-> scl [*3])
    else $error("scl fell too soon after start");
  a_addr_match: assert property (s_ninth ##0 byteCnt == 2'h0 |-> shiftR == 8'hDC)
    else $error("first byte is not the slave address");
  a_addr_ack: assert property (s_ninth ##0 byteCnt == 2'h0 |-> !sda)
    else $error("address byte not acknowledged");
  a_pair_ack: assert property (s_ninth ##0 byteCnt != 2'h0 |-> !sda [*3])
    else $error("byte ack missing or short");
  a_ack_timing: assert property ($rose(sdaDevOe) |-> !scl && bitCnt == 4'h8)
    else $error("slave pulled sda outside the ack slot");
  a_oe_bound: assert property (oeCnt <= OE_MAX)
    else $error("slave drove sda beyond one ack");
  a_stop_end: assert property ($fell(scl) && byteCnt == 2'h3
    |-> ##[1:40] (scl && sclQ && !sdaQ && sda))
    else $error("no stop after the data byte");
  a_open_drain: assert property (sdaDevOe |-> !sdaDevOut)
    else $error("slave drove sda high");
  a_host_drain: assert property (sclOe || sdaHostOe |-> !sclOut && !sdaHostOut)
    else $error("master drove a wire high");
endmodule
`default_nettype wire
